// ===== core/t1pm_pkg.sv
/*
  Shared constants for the receive performance-monitor counter bank:
  register indices, field positions, reset values and frame timing.
  Assumes a 25 MHz system clock and a receive framer on the same clock.
*/
package t1pm_pkg;

  // bus geometry: word index on the Avalon address, byte data in low lanes
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int BYTE_W = 8;

  // register indices; byte address is four times the index
  localparam logic [ADDR_W-1:0] FAE_HI_IDX   = 12'h0902;
  localparam logic [ADDR_W-1:0] FAE_LO_IDX   = 12'h0903;
  localparam logic [ADDR_W-1:0] SEF_IDX      = 12'h0904;
  localparam logic [ADDR_W-1:0] CRC_HI_IDX   = 12'h0905;
  localparam logic [ADDR_W-1:0] CRC_LO_IDX   = 12'h0906;
  localparam logic [ADDR_W-1:0] IRQ_STAT_IDX = 12'h0910;
  localparam logic [ADDR_W-1:0] IRQ_MASK_IDX = 12'h0911;
  localparam logic [ADDR_W-1:0] CTRL_IDX     = 12'h0912;

  // counter widths
  localparam int WIDE_CNT_W   = 16;
  localparam int NARROW_CNT_W = 8;

  // control register fields
  localparam int CTRL_ESF_BIT = 0;
  localparam int CTRL_EN_BIT  = 1;
  localparam int CTRL_W       = 2;
  localparam logic [CTRL_W-1:0] CTRL_RST = 2'h2;

  // interrupt status / mask fields
  localparam int IRQ_FAE_BIT = 0;
  localparam int IRQ_SEF_BIT = 1;
  localparam int IRQ_CRC_BIT = 2;
  localparam int IRQ_SAT_BIT = 3;
  localparam int IRQ_W       = 4;
  localparam logic [IRQ_W-1:0] IRQ_STAT_RST = 4'h0;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;

  // frame timing: one framing-bit check per 125 us frame
  localparam int CLK_HZ          = 25000000;
  localparam int FRAME_TIME_NS   = 125000;
  localparam int SEF_SF_TIME_NS  = 750000;
  localparam int SEF_ESF_TIME_NS = 3000000;
  localparam int SEF_SF_FRAMES   = SEF_SF_TIME_NS / FRAME_TIME_NS;
  localparam int SEF_ESF_FRAMES  = SEF_ESF_TIME_NS / FRAME_TIME_NS;
  localparam int SEF_RUN_W       = 5;

  typedef enum logic [1:0] {
    T1PM_BS_IDLE = 2'b01,
    T1PM_BS_ACK  = 2'b10
  } t1pm_bus_state_t;

endpackage

// ===== core/t1pm_sat_cnt.sv
/*
  Saturating event counter with a synchronous clear.
  Assumes inc_i and clr_i are single-cycle pulses on clk_sys_i.
*/
`timescale 1ns/1ps
module t1pm_sat_cnt #(
  parameter int W = 16
) (
  input  wire logic         clk_sys_i,
  input  wire logic         rst_b_i,
  input  wire logic         inc_i,
  input  wire logic         clr_i,
  output logic [W-1:0]      cnt_o,
  output logic              sat_o
);

  logic [W-1:0] cnt_q;

  if (W < 2) begin : g_chk
    $error("t1pm_sat_cnt: width below 2");
  end

  // an event that lands on the clearing read is kept as a count of one
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q <= '0;
    end else if (clr_i) begin
      cnt_q <= inc_i ? W'(1) : '0;
    end else if (inc_i && (cnt_q != {W{1'b1}})) begin
      cnt_q <= cnt_q + W'(1);
    end
  end

  assign cnt_o = cnt_q;
  assign sat_o = inc_i && !clr_i && (cnt_q == {W{1'b1}});

endmodule

// ===== core/t1pm_top.sv
/*
  Receive performance-monitor counter bank for a T1 framer: framing
  alignment errors, severely errored frames and CRC-6 bit errors, read
  over Avalon-MM, with sticky interrupt status and mask.
  Assumes the framer's event pulses are already on clk_sys_i (25 MHz).
*/
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// Contract
// RULE_01: keep a 16-bit count of framing alignment errors since last read.
// RULE_02: every counter byte clears to zero when software reads it.
// RULE_03: alignment count upper byte at 0x0902, lower byte at 0x0903.
// RULE_04: software reads the upper byte before the lower byte.
// RULE_05: clearing a 16-bit count takes upper then lower byte reads.
// RULE_06: keep an 8-bit count of severely errored frames since last read.
// RULE_07: framing bit errors over contiguous windows make a severe event.
// RULE_08: superframe mode: six frames of Ft errors in a row is severe.
// RULE_09: extended superframe mode: 24 frames of FPS errors is severe.
// RULE_10: keep a 16-bit CRC-6 error count, upper byte in its own register.
// RULE_11: CRC-6 count lower byte readable at 0x0906.
// RULE_12: upper-byte read snapshots the lower byte for the next read.
// RULE_13: counters stop at their maximum instead of wrapping.
module t1pm_top #(
  parameter int FAE_W = t1pm_pkg::WIDE_CNT_W,
  parameter int SEF_W = t1pm_pkg::NARROW_CNT_W,
  parameter int CRC_W = t1pm_pkg::WIDE_CNT_W
) (
  input  wire logic                           clk_sys_i,
  input  wire logic                           rst_b_i,
  input  wire logic [t1pm_pkg::ADDR_W-1:0]    avs_address_i,
  input  wire logic                           avs_read_i,
  input  wire logic                           avs_write_i,
  input  wire logic [t1pm_pkg::DATA_W-1:0]    avs_writedata_i,
  output logic      [t1pm_pkg::DATA_W-1:0]    avs_readdata_o,
  output logic                                avs_waitrequest_o,
  input  wire logic                           fae_event_i,
  input  wire logic                           frame_chk_i,
  input  wire logic                           frame_bit_err_i,
  input  wire logic                           crc6_err_event_i,
  output logic                                irq_o
);

  import t1pm_pkg::*;

  if (FAE_W != 2 * BYTE_W || CRC_W != 2 * BYTE_W || SEF_W != BYTE_W) begin : g_chk
    $error("t1pm_top: counters must be two bytes, or one for the severe count");
  end

  // the run counter must reach the longer window without wrapping
  if (SEF_SF_FRAMES >= (1 << SEF_RUN_W)
      || SEF_ESF_FRAMES >= (1 << SEF_RUN_W)) begin : g_run_chk
    $error("t1pm_top: frame run counter too narrow for the window");
  end

  // a window of no frames would wrap the run compare to the all-ones run count
  if (SEF_SF_FRAMES < 1 || SEF_ESF_FRAMES < 1) begin : g_win_chk
    $error("t1pm_top: severe frame window must be at least one frame");
  end

  // every readable field must fit the data lanes
  if (DATA_W < BYTE_W || DATA_W < IRQ_W || DATA_W < CTRL_W) begin : g_lane_chk
    $error("t1pm_top: data bus narrower than a register");
  end

  // field positions must sit inside their registers
  if (IRQ_FAE_BIT >= IRQ_W || IRQ_SEF_BIT >= IRQ_W
      || IRQ_CRC_BIT >= IRQ_W || IRQ_SAT_BIT >= IRQ_W) begin : g_irq_chk
    $error("t1pm_top: status bit outside the status register");
  end

  if (CTRL_ESF_BIT >= CTRL_W || CTRL_EN_BIT >= CTRL_W) begin : g_ctrl_chk
    $error("t1pm_top: control bit outside the control register");
  end

  // overlapping indices would let one read clear two counters
  if (FAE_HI_IDX == FAE_LO_IDX || FAE_HI_IDX == SEF_IDX || FAE_HI_IDX == CRC_HI_IDX
      || FAE_HI_IDX == CRC_LO_IDX || FAE_LO_IDX == SEF_IDX || FAE_LO_IDX == CRC_HI_IDX
      || FAE_LO_IDX == CRC_LO_IDX || SEF_IDX == CRC_HI_IDX || SEF_IDX == CRC_LO_IDX
      || CRC_HI_IDX == CRC_LO_IDX) begin : g_idx_chk
    $error("t1pm_top: two counters share a register index");
  end

  // a shared index would make a status read also hit a setting
  if (IRQ_STAT_IDX == IRQ_MASK_IDX || IRQ_STAT_IDX == CTRL_IDX
      || IRQ_MASK_IDX == CTRL_IDX) begin : g_reg_idx_chk
    $error("t1pm_top: control registers share an index");
  end

  // bus handshake
  t1pm_bus_state_t            bus_state_q;
  logic                       wait_q;
  logic [DATA_W-1:0]          rdata_q;
  logic [DATA_W-1:0]          rdata_d;
  logic                       accept;
  logic                       rd_acc;
  logic                       wr_acc;

  // register decode
  logic                       rd_fae_hi;
  logic                       rd_fae_lo;
  logic                       rd_sef;
  logic                       rd_crc_hi;
  logic                       rd_crc_lo;
  logic                       rd_stat;
  logic                       wr_mask;
  logic                       wr_ctrl;

  // counters and their snapshots
  logic [FAE_W-1:0]           fae_cnt;
  logic [SEF_W-1:0]           sef_cnt;
  logic [CRC_W-1:0]           crc_cnt;
  logic                       fae_clr;
  logic                       sef_clr;
  logic                       crc_clr;
  logic                       fae_sat;
  logic                       sef_sat;
  logic                       crc_sat;
  logic [BYTE_W-1:0]          fae_hold_q;
  logic                       fae_hold_vld_q;
  logic [BYTE_W-1:0]          crc_hold_q;
  logic                       crc_hold_vld_q;

  // severe frame detection
  logic [SEF_RUN_W-1:0]       run_q;
  logic [SEF_RUN_W-1:0]       run_lim;
  logic                       sef_pulse;

  // control and interrupts
  logic [CTRL_W-1:0]          ctrl_q;
  logic [IRQ_W-1:0]           stat_q;
  logic [IRQ_W-1:0]           mask_q;
  logic [IRQ_W-1:0]           ev_vec;
  logic                       irq_q;
  logic                       fae_inc;
  logic                       crc_inc;
  logic                       cnt_en;

  // one wait state per access: the request is taken on the edge that
  // drops waitrequest, the master samples the answer on the next edge
  assign accept = (bus_state_q == T1PM_BS_IDLE) && (avs_read_i || avs_write_i);
  assign rd_acc = accept && avs_read_i;
  assign wr_acc = accept && avs_write_i && !avs_read_i;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bus_state_q <= T1PM_BS_IDLE;
      wait_q      <= 1'b1;
    end else begin
      case (bus_state_q)
        T1PM_BS_IDLE: begin
          if (accept) begin
            bus_state_q <= T1PM_BS_ACK;
            wait_q      <= 1'b0;
          end
        end
        T1PM_BS_ACK: begin
          bus_state_q <= T1PM_BS_IDLE;
          wait_q      <= 1'b1;
        end
        default: begin
          bus_state_q <= T1PM_BS_IDLE;
          wait_q      <= 1'b1;
        end
      endcase
    end
  end

  always_comb begin
    rd_fae_hi = rd_acc && (avs_address_i == FAE_HI_IDX); // see RULE_03
    rd_fae_lo = rd_acc && (avs_address_i == FAE_LO_IDX); // see RULE_03
    rd_sef    = rd_acc && (avs_address_i == SEF_IDX);
    rd_crc_hi = rd_acc && (avs_address_i == CRC_HI_IDX); // see RULE_10
    rd_crc_lo = rd_acc && (avs_address_i == CRC_LO_IDX); // see RULE_11
    rd_stat   = rd_acc && (avs_address_i == IRQ_STAT_IDX);
    wr_mask   = wr_acc && (avs_address_i == IRQ_MASK_IDX);
    wr_ctrl   = wr_acc && (avs_address_i == CTRL_IDX);
  end

  assign cnt_en  = ctrl_q[CTRL_EN_BIT];
  assign fae_inc = cnt_en && fae_event_i;
  assign crc_inc = cnt_en && crc6_err_event_i;

  // the upper-byte read empties the live count; a lower-byte read with
  // no snapshot pending falls back to the live count and empties it
  assign fae_clr = rd_fae_hi || (rd_fae_lo && !fae_hold_vld_q); // see RULE_02
  assign crc_clr = rd_crc_hi || (rd_crc_lo && !crc_hold_vld_q); // see RULE_02
  assign sef_clr = rd_sef; // see RULE_02

  t1pm_sat_cnt #(
    .W (FAE_W)
  ) u_fae_cnt (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .inc_i     (fae_inc),
    .clr_i     (fae_clr),
    .cnt_o     (fae_cnt),
    .sat_o     (fae_sat)
  ); // see RULE_01, see RULE_13

  t1pm_sat_cnt #(
    .W (SEF_W)
  ) u_sef_cnt (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .inc_i     (sef_pulse),
    .clr_i     (sef_clr),
    .cnt_o     (sef_cnt),
    .sat_o     (sef_sat)
  ); // see RULE_06, see RULE_13

  t1pm_sat_cnt #(
    .W (CRC_W)
  ) u_crc_cnt (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .inc_i     (crc_inc),
    .clr_i     (crc_clr),
    .cnt_o     (crc_cnt),
    .sat_o     (crc_sat)
  ); // see RULE_10, see RULE_13

  // snapshot of the lower byte, so an event between the two byte reads
  // cannot tear the pair; it lands in the next count instead
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fae_hold_q     <= '0;
      fae_hold_vld_q <= 1'b0;
    end else if (rd_fae_hi) begin
      fae_hold_q     <= fae_cnt[BYTE_W-1:0]; // see RULE_12, see RULE_04
      fae_hold_vld_q <= 1'b1;
    end else if (rd_fae_lo) begin
      fae_hold_q     <= '0; // see RULE_05
      fae_hold_vld_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      crc_hold_q     <= '0;
      crc_hold_vld_q <= 1'b0;
    end else if (rd_crc_hi) begin
      crc_hold_q     <= crc_cnt[BYTE_W-1:0]; // see RULE_12, see RULE_04
      crc_hold_vld_q <= 1'b1;
    end else if (rd_crc_lo) begin
      crc_hold_q     <= '0; // see RULE_05
      crc_hold_vld_q <= 1'b0;
    end
  end

  // run of consecutive frames with a bad framing bit; each full run is
  // one severe event and the next window starts afresh
  assign run_lim = ctrl_q[CTRL_ESF_BIT] ? SEF_RUN_W'(SEF_ESF_FRAMES)
                                        : SEF_RUN_W'(SEF_SF_FRAMES); // see RULE_08, see RULE_09
  assign sef_pulse = cnt_en && frame_chk_i && frame_bit_err_i
                     && (run_q == run_lim - SEF_RUN_W'(1)); // see RULE_07

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      run_q <= '0;
    end else if (!cnt_en || wr_ctrl) begin
      // a mode change restarts the window rather than mixing two lengths
      run_q <= '0;
    end else if (frame_chk_i) begin
      if (!frame_bit_err_i || sef_pulse) begin
        run_q <= '0; // see RULE_07
      end else begin
        run_q <= run_q + SEF_RUN_W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_q <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= avs_writedata_i[CTRL_W-1:0];
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mask_q <= IRQ_MASK_RST;
    end else if (wr_mask) begin
      mask_q <= avs_writedata_i[IRQ_W-1:0];
    end
  end

  always_comb begin
    ev_vec              = '0;
    ev_vec[IRQ_FAE_BIT] = fae_inc;
    ev_vec[IRQ_SEF_BIT] = sef_pulse;
    ev_vec[IRQ_CRC_BIT] = crc_inc;
    ev_vec[IRQ_SAT_BIT] = fae_sat || sef_sat || crc_sat;
  end

  // read clears the status, but an event in that same cycle survives
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stat_q <= IRQ_STAT_RST;
    end else if (rd_stat) begin
      stat_q <= ev_vec;
    end else begin
      stat_q <= stat_q | ev_vec;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(stat_q & mask_q);
    end
  end

  always_comb begin
    rdata_d = '0;
    if (rd_acc) begin
      case (avs_address_i)
        FAE_HI_IDX:   rdata_d[BYTE_W-1:0] = fae_cnt[FAE_W-1:BYTE_W]; // see RULE_03
        FAE_LO_IDX:   rdata_d[BYTE_W-1:0] = fae_hold_vld_q ? fae_hold_q
                                                           : fae_cnt[BYTE_W-1:0];
        SEF_IDX:      rdata_d[BYTE_W-1:0] = sef_cnt; // see RULE_06
        CRC_HI_IDX:   rdata_d[BYTE_W-1:0] = crc_cnt[CRC_W-1:BYTE_W]; // see RULE_10
        CRC_LO_IDX:   rdata_d[BYTE_W-1:0] = crc_hold_vld_q ? crc_hold_q
                                                           : crc_cnt[BYTE_W-1:0]; // see RULE_11
        IRQ_STAT_IDX: rdata_d[IRQ_W-1:0]  = stat_q;
        IRQ_MASK_IDX: rdata_d[IRQ_W-1:0]  = mask_q;
        CTRL_IDX:     rdata_d[CTRL_W-1:0] = ctrl_q;
        default:      rdata_d = '0;
      endcase
    end
  end

  // read data is held through the answer cycle and zero otherwise
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign avs_readdata_o    = rdata_q;
  assign avs_waitrequest_o = wait_q;
  assign irq_o             = irq_q;

endmodule

// ===== test/t1_rx_error_counters_tb_top.sv
/* Self-checking bench for t1pm_top: counts, read-clear, severe frames,
   saturation and interrupt. Host model drives the bus, bench the events. */
`timescale 1ns/1ps
module t1_rx_error_counters_tb_top;
  import t1pm_pkg::*;
  logic              clk_sys_i;
  logic              rst_b_i = 1'b0;
  logic [ADDR_W-1:0] adr;
  logic              rd;
  logic              wr_en;
  logic [DATA_W-1:0] wdat;
  logic [DATA_W-1:0] rdat;
  logic              wait_q;
  logic              fae_event_i = 1'b0;
  logic              frame_chk_i = 1'b0;
  logic              frame_bit_err_i = 1'b0;
  logic              crc6_err_event_i = 1'b0;
  logic              irq_o;
  logic [15:0]       v;
  int                fails = 0;
  int                compares = 0;
  logic [ADDR_W-1:0] ra [8] = '{FAE_HI_IDX, FAE_LO_IDX, SEF_IDX, CRC_HI_IDX, CRC_LO_IDX,
                               IRQ_STAT_IDX, IRQ_MASK_IDX, CTRL_IDX};

  t1pm_top dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr_en), .avs_writedata_i(wdat), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wait_q), .fae_event_i(fae_event_i), .frame_chk_i(frame_chk_i),
    .frame_bit_err_i(frame_bit_err_i), .crc6_err_event_i(crc6_err_event_i), .irq_o(irq_o));
  t1pm_host_model host (.clk_sys_i(clk_sys_i), .avs_readdata_i(rdat),
    .avs_waitrequest_i(wait_q), .avs_address_o(adr), .avs_read_o(rd),
    .avs_write_o(wr_en), .avs_writedata_o(wdat));

  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  task automatic chk(input string nm, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    logic [DATA_W-1:0] d;
    host.xfer(a, 1'b0, '0, d);
    chk($sformatf("register %h", a), e, d);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] s;
    host.xfer(a, 1'b1, d, s);
  endtask

  // k: 0 alignment error, 1 framing check, 2 crc error; one per cycle
  task automatic pulse(input int k, input int n, input logic e);
    @(posedge clk_sys_i);
    repeat (n) begin
      fae_event_i <= (k == 0);
      frame_chk_i <= (k == 1);
      crc6_err_event_i <= (k == 2);
      frame_bit_err_i <= e;
      @(posedge clk_sys_i);
    end
    {fae_event_i, frame_chk_i, crc6_err_event_i, frame_bit_err_i} <= 4'h0;
  endtask

  task automatic irq_is(input logic e);
    repeat (2) @(negedge clk_sys_i);
    chk("irq", {31'h0000_0000, e}, {31'h0000_0000, irq_o});
  endtask

  task automatic end_of_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (10000) @(posedge clk_sys_i);
    fails++;
    end_of_test();
  end

  initial begin
    repeat (5) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    wr(FAE_LO_IDX, 32'h0000_00ff);
    for (int i = 0; i < 8; i++) rc(ra[i], (i == 7) ? 32'h0000_0002 : 32'h0000_0000);
    rc(12'h0800, 32'h0000_0000);
    pulse(0, 300, 1'b0);
    rc(FAE_HI_IDX, 32'h0000_0001);
    pulse(0, 1, 1'b0);
    rc(FAE_LO_IDX, 32'h0000_002c);
    host.rd16(FAE_HI_IDX, v);
    chk("align count", 32'h0000_0001, {16'h0000, v});
    pulse(2, 5, 1'b0);
    host.rd16(CRC_HI_IDX, v);
    chk("crc count", 32'h0000_0005, {16'h0000, v});
    rc(CRC_LO_IDX, 32'h0000_0000);
    pulse(1, 5, 1'b1);
    pulse(1, 1, 1'b0);
    pulse(1, 6, 1'b1);
    rc(SEF_IDX, 32'h0000_0001);
    rc(SEF_IDX, 32'h0000_0000);
    wr(CTRL_IDX, 32'h0000_0003);
    pulse(1, 23, 1'b1);
    rc(SEF_IDX, 32'h0000_0000);
    pulse(1, 1, 1'b1);
    rc(SEF_IDX, 32'h0000_0001);
    wr(CTRL_IDX, 32'h0000_0000);
    pulse(0, 3, 1'b0);
    rc(FAE_LO_IDX, 32'h0000_0000);
    wr(CTRL_IDX, 32'h0000_0002);
    pulse(1, 1560, 1'b1);
    rc(SEF_IDX, 32'h0000_00ff);
    rc(IRQ_STAT_IDX, 32'h0000_000f);
    pulse(0, 1, 1'b0);
    irq_is(1'b0);
    wr(IRQ_MASK_IDX, 32'h0000_0001);
    irq_is(1'b1);
    rc(IRQ_STAT_IDX, 32'h0000_0001);
    irq_is(1'b0);
    end_of_test();
  end
endmodule

// ===== test/t1pm_host_model.sv
/* Host model: single Avalon-MM reads and writes, 16-bit count reads.
   Assumes tasks are entered just after a rising edge. */
`timescale 1ns/1ps
module t1pm_host_model
  import t1pm_pkg::*;
(
  input  wire logic                        clk_sys_i,
  input  wire logic [t1pm_pkg::DATA_W-1:0] avs_readdata_i,
  input  wire logic                        avs_waitrequest_i,
  output logic      [t1pm_pkg::ADDR_W-1:0] avs_address_o,
  output logic                             avs_read_o,
  output logic                             avs_write_o,
  output logic      [t1pm_pkg::DATA_W-1:0] avs_writedata_o
);
  initial begin
    avs_address_o = '0;
    avs_read_o = 1'b0;
    avs_write_o = 1'b0;
    avs_writedata_o = '0;
  end

  task automatic xfer(input logic [ADDR_W-1:0] a, input logic w,
                      input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] d);
    @(posedge clk_sys_i);
    avs_address_o <= a;
    avs_read_o <= !w;
    avs_write_o <= w;
    avs_writedata_o <= wd;
    do @(posedge clk_sys_i); while (avs_waitrequest_i !== 1'b0);
    d = avs_readdata_i;
    avs_read_o <= 1'b0;
    avs_write_o <= 1'b0;
    avs_writedata_o <= ~wd;
  endtask

  // upper byte first, so the lower byte comes from its snapshot
  task automatic rd16(input logic [ADDR_W-1:0] hi, output logic [15:0] v);
    logic [DATA_W-1:0] h;
    logic [DATA_W-1:0] l;
    xfer(hi, 1'b0, '0, h);
    xfer(hi + 12'h001, 1'b0, '0, l);
    v = {h[7:0], l[7:0]};
  endtask
endmodule

// ===== test/t1pm_top_properties.sv
/* Checker for bus timing, read-clear and interrupt timing of t1pm_top.
   Sees only the top ports; bound onto every t1pm_top below. */
`timescale 1ns/1ps
module t1pm_chk
  import t1pm_pkg::*;
#(
  parameter int FAE_W = 16,
  parameter int SEF_W = 8,
  parameter int CRC_W = 16
) (
  input wire logic                        clk_sys_i,
  input wire logic                        rst_b_i,
  input wire logic [t1pm_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic                        avs_read_i,
  input wire logic                        avs_write_i,
  input wire logic [t1pm_pkg::DATA_W-1:0] avs_readdata_o,
  input wire logic                        avs_waitrequest_o,
  input wire logic                        fae_event_i,
  input wire logic                        frame_chk_i,
  input wire logic                        crc6_err_event_i,
  input wire logic                        irq_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);

  ans_one_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("request not answered after one wait");
  wait_one_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("answer held longer than one cycle");
  idle_zero_a: assert property (avs_waitrequest_o |-> avs_readdata_o == '0)
    else $error("read data not zero while idle");
  byte_lane_a: assert property (avs_readdata_o[31:8] == '0)
    else $error("read data above the byte lane");
  wr_nodata_a: assert property (avs_write_i && !avs_read_i && avs_waitrequest_o
    |=> avs_readdata_o == '0) else $error("write answered with data");
  irq_rise_a: assert property ($rose(irq_o)
    |-> $past(fae_event_i | frame_chk_i | crc6_err_event_i | avs_write_i, 2))
    else $error("interrupt rose without a cause");
  irq_fall_a: assert property ($fell(irq_o) |-> $past(avs_read_i | avs_write_i, 2))
    else $error("interrupt fell without an access");
  clr_read_a: assert property (avs_read_i && avs_waitrequest_o && avs_address_i == SEF_IDX
    && !frame_chk_i ##1 !frame_chk_i [*2] ##1 avs_read_i && avs_waitrequest_o
    && avs_address_i == SEF_IDX |=> avs_readdata_o == '0) else $error("count kept after read");
endmodule

bind t1pm_top t1pm_chk #(.FAE_W(FAE_W), .SEF_W(SEF_W), .CRC_W(CRC_W)) u_chk (
  .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .fae_event_i(fae_event_i),
  .frame_chk_i(frame_chk_i), .crc6_err_event_i(crc6_err_event_i), .irq_o(irq_o));
